//--- pif_pkg.sv
// Purpose: shared constants of the peripheral interrupt flag block
// Assumes: 8-bit flag register behind a 32-bit classic Wishbone slave
// Notes:   byte addresses, one aligned word per register
package pif_pkg;
    // ============================================================
    // register map
    localparam logic [7:0] FLAGS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS  = 8'h04;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic [7:0] W1C_BITS  = 8'hcf;
    // ============================================================
    // flag bit positions
    localparam int PAR_BIT    = 7;
    localparam int CONV_BIT   = 6;
    localparam int RX_BIT     = 5;
    localparam int TX_BIT     = 4;
    localparam int SYNC_BIT   = 3;
    localparam int CAPCMP_BIT = 2;
    localparam int PERIOD_BIT = 1;
    localparam int OVF_BIT    = 0;
    // ============================================================
    // capture/compare unit modes
    localparam logic [1:0] CCP_OFF     = 2'h0;
    localparam logic [1:0] CCP_CAPTURE = 2'h1;
    localparam logic [1:0] CCP_COMPARE = 2'h2;
    localparam logic [1:0] CCP_PWM     = 2'h3;
endpackage

//--- pif_flag_bit.sv
// Purpose: one sticky flag with independent set and clear
// Assumes: set and clear are one-cycle terms on the same clock
// Notes:   an unimplemented bit stays at zero
`timescale 1ns/100ps
module pif_flag_bit #(
    parameter bit IMPL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    // ============================================================
    // flag storage
    // set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i || !IMPL) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule

//--- pif_wb_slave.sv
// Purpose: classic Wishbone slave front end, one wait state
// Assumes: master holds the request until it samples ack
// Notes:   write commits on the edge where ack is high
`timescale 1ns/100ps
module pif_wb_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [7:0]  rdata_i,
    output logic             ack_o,
    output logic [31:0]      dat_o,
    output logic             wr_o
);
    logic req;

    // ============================================================
    // handshake
    assign req  = cyc_i && stb_i;
    // lane 0 carries all data; other lanes are ignored
    assign wr_o = req && ack_o && we_i && sel_i[0];

    // ack falls the cycle after it rose, even if stb stays high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req && !ack_o;
        end
    end

    // read data captured together with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !ack_o && !we_i) begin
            dat_o <= {24'h00_0000, rdata_i};
        end
    end
endmodule

//--- pif_top.sv
// Purpose: peripheral interrupt flag register with mask and irq
// Assumes: all peripheral events come from logic on clk_i
// Notes:   flags set regardless of mask; irq is registered
// Functional notes
// R1: flags set regardless of any enable bit
// R2: conversion done sets bit 6; software clears
// R3: bit 5 set on receive, cleared by read
// R4: bit 4 set when transmit empty, cleared by write
// R5: bit 4 reads 0 while transmit buffer full
// R6: capture mode: capture sets bit 2
// R7: compare mode: match sets bit 2
// R8: pwm mode never sets bit 2
// R9: second timer period match sets bit 1
// R10: first timer overflow sets bit 0
// R11: no parallel port: bit 7 reserved
// R12: no converter: bit 6 reserved
// R13: parallel port access done sets bit 7
// R14: sync serial transfer done sets bit 3
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module pif_top
    import pif_pkg::*;
#(
    parameter bit HAS_PAR_PORT = 1'b1,
    parameter bit HAS_CONV     = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        par_port_done_i,
    input  wire logic        conv_done_i,
    input  wire logic        rx_load_i,
    input  wire logic        rx_data_rd_i,
    input  wire logic        tx_unload_i,
    input  wire logic        tx_data_wr_i,
    input  wire logic        tx_buf_full_i,
    input  wire logic        sync_serial_done_i,
    input  wire logic [1:0]  ccp_mode_i,
    input  wire logic        ccp_capture_i,
    input  wire logic        ccp_match_i,
    input  wire logic        period_match_i,
    input  wire logic        timer_overflow_i,
    output logic [7:0]       flags_o,
    output logic             irq_o
);
    // ============================================================
    // declarations
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] flags;
    logic [7:0] mask_q;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic       bus_wr;
    logic       wr_flags;
    logic       wr_mask;
    logic       capcmp_evt;
    // absent units leave their bit permanently zero
    localparam logic [7:0] IMPL_VEC =
        {HAS_PAR_PORT, HAS_CONV, 6'h3f}; // R11 R12

    // ============================================================
    // bus front end
    pif_wb_slave u_bus (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .cyc_i   (wb_cyc_i),
        .stb_i   (wb_stb_i),
        .we_i    (wb_we_i),
        .sel_i   (wb_sel_i),
        .rdata_i (rdata),
        .ack_o   (wb_ack_o),
        .dat_o   (wb_dat_o),
        .wr_o    (bus_wr)
    );

    // write decode
    assign wdata    = wb_dat_i[7:0];
    assign wr_flags = bus_wr && (wb_adr_i == FLAGS_OFS);
    assign wr_mask  = bus_wr && (wb_adr_i == MASK_OFS);

    // read mux; unmapped words read zero and still ack
    always_comb begin
        rdata = 8'h00;
        case (wb_adr_i)
            FLAGS_OFS: rdata = flags;
            MASK_OFS:  rdata = mask_q;
            default:   rdata = 8'h00;
        endcase
    end

    // ============================================================
    // event sources
    // capture and compare share one flag; pwm and off raise nothing
    always_comb begin
        capcmp_evt = 1'b0;
        case (ccp_mode_i)
            CCP_CAPTURE: capcmp_evt = ccp_capture_i; // R6
            CCP_COMPARE: capcmp_evt = ccp_match_i; // R7
            CCP_PWM:     capcmp_evt = 1'b0; // R8
            default:     capcmp_evt = 1'b0;
        endcase
    end

    // no enable or mask term here: flags latch unconditionally
    always_comb begin
        set_vec             = 8'h00; // R1
        set_vec[PAR_BIT]    = par_port_done_i; // R13
        set_vec[CONV_BIT]   = conv_done_i; // R2
        set_vec[RX_BIT]     = rx_load_i; // R3
        set_vec[TX_BIT]     = tx_unload_i && !tx_buf_full_i; // R4
        set_vec[SYNC_BIT]   = sync_serial_done_i; // R14
        set_vec[CAPCMP_BIT] = capcmp_evt;
        set_vec[PERIOD_BIT] = period_match_i; // R9
        set_vec[OVF_BIT]    = timer_overflow_i; // R10
    end

    // software clears by writing ones; buffer bits are read-only
    always_comb begin
        clr_vec         = wr_flags ? (wdata & W1C_BITS) : 8'h00;
        clr_vec[RX_BIT] = rx_data_rd_i; // R3
        // a full transmit buffer forces the flag low
        clr_vec[TX_BIT] = tx_data_wr_i || tx_buf_full_i; // R4 R5
    end

    // ============================================================
    // flag storage, one sticky cell per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            pif_flag_bit #(
                .IMPL (IMPL_VEC[gi])
            ) u_flag (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .set_i  (set_vec[gi]),
                .clr_i  (clr_vec[gi]),
                .flag_o (flags[gi])
            );
        end
    endgenerate

    assign flags_o = flags;

    // ============================================================
    // mask and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= MASK_RST;
        end else if (wr_mask) begin
            mask_q <= wdata;
        end
    end

    // registered so the pin never glitches; costs one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags & mask_q);
        end
    end

    // ============================================================
    // assertions
    property p_evt_no_mask;
        @(posedge clk_i) disable iff (rst_i)
        (timer_overflow_i && mask_q == 8'h00) |=> flags[OVF_BIT];
    endproperty
    a_evt_no_mask: assert property (p_evt_no_mask) // R1
        else $error("overflow flag not set with mask clear");

    property p_conv_set;
        @(posedge clk_i) disable iff (rst_i)
        (conv_done_i && HAS_CONV) |=> flags[CONV_BIT];
    endproperty
    a_conv_set: assert property (p_conv_set) // R2
        else $error("conversion flag not set");

    property p_rx_set;
        @(posedge clk_i) disable iff (rst_i)
        rx_load_i |=> flags[RX_BIT] [*1];
    endproperty
    a_rx_set: assert property (p_rx_set) // R3
        else $error("receive flag not set on load");

    property p_rx_clr;
        @(posedge clk_i) disable iff (rst_i)
        (rx_data_rd_i && !rx_load_i) |=> !flags[RX_BIT];
    endproperty
    a_rx_clr: assert property (p_rx_clr) // R3
        else $error("receive flag not cleared by read");

    property p_tx_clr;
        @(posedge clk_i) disable iff (rst_i)
        (tx_data_wr_i && !tx_unload_i) |=> !flags[TX_BIT];
    endproperty
    a_tx_clr: assert property (p_tx_clr) // R4
        else $error("transmit flag not cleared by write");

    property p_tx_full;
        @(posedge clk_i) disable iff (rst_i)
        tx_buf_full_i [*2] |-> !flags[TX_BIT];
    endproperty
    a_tx_full: assert property (p_tx_full) // R5
        else $error("transmit flag high while buffer full");

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        (ccp_mode_i == CCP_CAPTURE && ccp_capture_i)
            |=> flags[CAPCMP_BIT];
    endproperty
    a_capture: assert property (p_capture) // R6
        else $error("capture did not set flag");

    property p_compare;
        @(posedge clk_i) disable iff (rst_i)
        (ccp_mode_i == CCP_COMPARE && ccp_match_i)
            |=> flags[CAPCMP_BIT];
    endproperty
    a_compare: assert property (p_compare) // R7
        else $error("compare match did not set flag");

    property p_pwm_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (ccp_mode_i == CCP_PWM && !flags[CAPCMP_BIT])
            |=> !flags[CAPCMP_BIT];
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet) // R8
        else $error("flag set in pwm mode");

    property p_period;
        @(posedge clk_i) disable iff (rst_i)
        period_match_i |=> flags[PERIOD_BIT];
    endproperty
    a_period: assert property (p_period) // R9
        else $error("period match did not set flag");

    property p_ovf_w1c;
        @(posedge clk_i) disable iff (rst_i)
        (wr_flags && wdata[OVF_BIT] && !timer_overflow_i)
            |=> !flags[OVF_BIT];
    endproperty
    a_ovf_w1c: assert property (p_ovf_w1c) // R10
        else $error("overflow flag not cleared by write");

    property p_par_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        !HAS_PAR_PORT |-> !flags[PAR_BIT];
    endproperty
    a_par_rsvd: assert property (p_par_rsvd) // R11
        else $error("reserved parallel flag set");

    property p_conv_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        !HAS_CONV |-> !flags[CONV_BIT];
    endproperty
    a_conv_rsvd: assert property (p_conv_rsvd) // R12
        else $error("reserved conversion flag set");

    property p_par_set;
        @(posedge clk_i) disable iff (rst_i)
        (par_port_done_i && HAS_PAR_PORT) |=> flags[PAR_BIT];
    endproperty
    a_par_set: assert property (p_par_set) // R13
        else $error("parallel port flag not set");

    property p_sync_set;
        @(posedge clk_i) disable iff (rst_i)
        sync_serial_done_i |=> flags[SYNC_BIT];
    endproperty
    a_sync_set: assert property (p_sync_set) // R14
        else $error("sync serial flag not set");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (|(flags & mask_q)) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq missing for unmasked flag");

    property p_irq_low;
        @(posedge clk_i) disable iff (rst_i)
        (mask_q == 8'h00) [*2] |-> !irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("irq high with mask clear");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_ack_req;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("no ack one cycle after request");

    property p_rd_data;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
            && wb_adr_i == FLAGS_OFS) |=> wb_dat_o == {24'h0, $past(flags)};
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data does not match flags");

    property p_sw_no_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr_flags && set_vec == 8'h00) |=> (flags & ~$past(flags)) == 8'h00;
    endproperty
    a_sw_no_set: assert property (p_sw_no_set) // R1
        else $error("register write raised a flag");

    property p_rx_hold;
        @(posedge clk_i) disable iff (rst_i)
        (flags[RX_BIT] && !rx_data_rd_i) |=> flags[RX_BIT];
    endproperty
    a_rx_hold: assert property (p_rx_hold) // R3
        else $error("receive flag dropped without read");

    property p_tx_set;
        @(posedge clk_i) disable iff (rst_i)
        (tx_unload_i && !tx_buf_full_i) |=> flags[TX_BIT];
    endproperty
    a_tx_set: assert property (p_tx_set) // R4
        else $error("transmit flag not set when empty");

    property p_tx_full_now;
        @(posedge clk_i) disable iff (rst_i)
        tx_buf_full_i |=> !flags[TX_BIT];
    endproperty
    a_tx_full_now: assert property (p_tx_full_now) // R5
        else $error("transmit flag set while buffer full");

    property p_mask_wr;
        @(posedge clk_i) disable iff (rst_i)
        wr_mask |=> mask_q == $past(wdata);
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("mask write did not land");
endmodule

//--- pif_core_model.sv
// Purpose: core-side software model, a classic Wishbone master
// Assumes: slave answers with ack on clk_i, request held until then
// Notes:   no latency assumed; only the bench watchdog ends a hang
`timescale 1ns/100ps
module pif_core_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    // ============================================================
    // idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // ============================================================
    // one single cycle; software clears flags by writing ones here
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= adr;
        sel_o <= 4'h1;
        dat_o <= wd;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // stale data must not look valid once released
        dat_o <= ~wd;
    endtask
endmodule

//--- pif_top_test.sv
// Purpose: self-checking bench of the peripheral interrupt flags
// Assumes: event inputs pulse one cycle, tx buffer full held longer, driven at the rising edge
// Notes:   outputs judged at the falling edge, after updates land
`timescale 1ns/100ps
module pif_top_test;
    import pif_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [11:0] ev;
    logic [1:0]  mode;
    logic [7:0]  flags;
    logic [7:0]  flags_rsvd;
    logic [31:0] fl;
    logic        irq;
    logic [31:0] q;
    int          n_mismatch;
    int          check_count;
    int          bits[5] = '{7, 6, 3, 1, 0};
    int          evs[5]  = '{0, 1, 7, 10, 11};

    assign fl = {24'h0, flags};

    // ============================================================
    // clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    pif_core_model core (
        .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    pif_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .par_port_done_i(ev[0]),
        .conv_done_i(ev[1]), .rx_load_i(ev[2]), .rx_data_rd_i(ev[3]),
        .tx_unload_i(ev[4]), .tx_data_wr_i(ev[5]), .tx_buf_full_i(ev[6]),
        .sync_serial_done_i(ev[7]), .ccp_mode_i(mode),
        .ccp_capture_i(ev[8]), .ccp_match_i(ev[9]),
        .period_match_i(ev[10]), .timer_overflow_i(ev[11]),
        .flags_o(flags), .irq_o(irq));

    // reduced variant: no parallel port, no converter
    pif_top #(.HAS_PAR_PORT(1'b0), .HAS_CONV(1'b0)) uut_rsvd (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(), .wb_ack_o(), .par_port_done_i(ev[0]),
        .conv_done_i(ev[1]), .rx_load_i(ev[2]), .rx_data_rd_i(ev[3]),
        .tx_unload_i(ev[4]), .tx_data_wr_i(ev[5]), .tx_buf_full_i(ev[6]),
        .sync_serial_done_i(ev[7]), .ccp_mode_i(mode),
        .ccp_capture_i(ev[8]), .ccp_match_i(ev[9]),
        .period_match_i(ev[10]), .timer_overflow_i(ev[11]),
        .flags_o(flags_rsvd), .irq_o());

    // ============================================================
    // shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        core.access(1'b1, a, d, r);
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        core.access(1'b0, a, 32'h0, q);
    endtask

    // one-cycle event pulse, flag visible at the following falling edge
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev <= ev | (12'h001 << i);
        @(posedge clk_i);
        ev <= ev & ~(12'h001 << i);
        @(negedge clk_i);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        rd(FLAGS_OFS);
        check(q, {24'h0, FLAGS_RST});
        rd(MASK_OFS);
        check(q, {24'h0, MASK_RST});
        check({31'h0, irq}, 32'h0);
    endtask

    // each software-cleared flag except bit 2: set with mask off, write 0, write 1
    task automatic t_sticky();
        for (int k = 0; k < 5; k++) begin
            pulse(evs[k]);
            check(fl, 32'h1 << bits[k]);
            check({24'h0, flags_rsvd}, (32'h1 << bits[k]) & 32'h3f);
            check({31'h0, irq}, 32'h0);
            rd(FLAGS_OFS);
            check(q, 32'h1 << bits[k]);
            wr(FLAGS_OFS, 32'h0);
            check(fl, 32'h1 << bits[k]);
            wr(FLAGS_OFS, 32'h1 << bits[k]);
            check(fl, 32'h0);
        end
    endtask

    task automatic t_serial();
        pulse(2);
        check(fl, 32'h20);
        wr(FLAGS_OFS, 32'h30);
        check(fl, 32'h20);
        pulse(3);
        check(fl, 32'h0);
        pulse(4);
        check(fl, 32'h10);
        @(posedge clk_i);
        ev[6] <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        check(fl, 32'h0);
        pulse(4);
        check(fl, 32'h0);
        @(posedge clk_i);
        ev[6] <= 1'b0;
        pulse(4);
        check(fl, 32'h10);
        pulse(5);
        check(fl, 32'h0);
    endtask

    // capture and match in every unit mode
    task automatic t_ccp();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            mode <= 2'(m);
            pulse(8);
            check(fl, {29'h0, 2'(m) == CCP_CAPTURE, 2'h0});
            wr(FLAGS_OFS, 32'h4);
            pulse(9);
            check(fl, {29'h0, 2'(m) == CCP_COMPARE, 2'h0});
            wr(FLAGS_OFS, 32'h4);
        end
    endtask

    // irq follows unmasked flags one cycle late; unmapped reads zero
    task automatic t_irq();
        wr(MASK_OFS, 32'h1);
        rd(MASK_OFS);
        check(q, 32'h1);
        pulse(11);
        check({31'h0, irq}, 32'h0);
        @(negedge clk_i);
        check({31'h0, irq}, 32'h1);
        pulse(10);
        wr(FLAGS_OFS, 32'h1);
        @(negedge clk_i);
        check({31'h0, irq}, 32'h0);
        check(fl, 32'h2);
        rd(8'h08);
        check(q, 32'h0);
        wr(FLAGS_OFS, 32'h2);
    endtask

    // ============================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst_i = 1'b1;
        ev = 12'h0;
        mode = CCP_OFF;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sticky();
        t_serial();
        t_ccp();
        t_irq();
        tally_and_finish();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(5000 * 100);
        n_mismatch++;
        $display("Error at %0t: timeout", $time);
        tally_and_finish();
    end
endmodule
